// file: hdl/ssp_pkg.sv
// Constants and types for the serial slave host port
package ssp_pkg;
    // Register byte offsets
    localparam logic [7:0] SSP_CTRL_OFS = 8'h00;
    localparam logic [7:0] SSP_STAT_OFS = 8'h04;
    // Control field positions and reset value
    localparam int         CTRL_MSB  = 0;
    localparam int         CTRL_FALL = 1;
    localparam int         CTRL_WDUM = 2;
    localparam int         CTRL_RDLY = 5;
    localparam int         CTRL_WAKE = 8;
    localparam logic [8:0] CTRL_RST  = 9'h001;
    // Status field positions
    localparam int         ST_FMT  = 0;
    localparam int         ST_RDF  = 1;
    localparam int         ST_WRF  = 2;
    localparam int         ST_LEN  = 3;
    localparam int         ST_BUSY = 4;
    // Header op codes
    localparam logic [1:0] OP_RD  = 2'b00;
    localparam logic [1:0] OP_WR  = 2'b01;
    localparam logic [1:0] OP_TBL = 2'b10;
    localparam logic [1:0] OP_RSV = 2'b11;
    // Header and table layout
    localparam logic [3:0] CID_MAX   = 4'h7;
    localparam int         TBL_DEPTH = 8;
    localparam logic [4:0] HDR0_LAST = 5'h1F;
    localparam logic [4:0] HDR1_LAST = 5'h07;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [8:0] TBL_BYTES = 9'h005;
    // AXI responses
    localparam logic [1:0] RESP_OK     = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR  = 3'b001,
        ST_TBL  = 3'b010,
        ST_WDUM = 3'b011,
        ST_WDAT = 3'b100,
        ST_RDLY = 3'b101,
        ST_RDAT = 3'b110,
        ST_HOLD = 3'b111
    } ssp_state_t;
endpackage

// file: hdl/ssp_serial_slave_host_port.sv
// Serial slave host port with AXI4-Lite control and status
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ssp_serial_slave_host_port
    import ssp_pkg::*;
#(
    parameter logic [23:0] SDIO_BASE = 24'hFF0000,
    parameter logic [23:0] SDIO_MASK = 24'hFF0000
)(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        link_clk,
    input  wire logic        host_select_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic             core_cmd_valid,
    output logic             core_cmd_write,
    output logic [23:0]      core_cmd_addr,
    output logic [8:0]       core_cmd_len,
    output logic             core_rd_req,
    output logic [23:0]      core_rd_addr,
    input  wire logic        core_rd_valid,
    input  wire logic [31:0] core_rd_data,
    output logic             core_wr_valid,
    output logic [23:0]      core_wr_addr,
    output logic [31:0]      core_wr_data,
    output logic [3:0]       core_wr_be,
    input  wire logic        core_wr_ack,
    output logic             wake_req,
    output logic             irq
);
    function automatic logic is_sdio(input logic [23:0] a);
        is_sdio = (a & SDIO_MASK) == SDIO_BASE;
    endfunction

    function automatic logic [23:0] adv(input logic [23:0] a);
        adv = is_sdio(a) ? a : a + 24'h000001;
    endfunction

    logic [2:0]  sck_q, sel_q;
    logic [1:0]  mosi_q;
    logic [8:0]  ctrl_q;
    logic [3:0]  flag_q;
    ssp_state_t  state_q;
    logic [31:0] sh_q, sh_n, rhold_q, wbuf_q, wmerge;
    logic [4:0]  bit_q;
    logic [8:0]  rem_q, dec_len;
    logic [2:0]  dum_q, cid_q;
    logic [23:0] addr_q, dec_addr;
    logic [7:0]  osh_q, dbyte, rbyte;
    logic [39:0] tsh_q;
    logic [3:0]  wbe_q, wbe_m, lat, dec_cid;
    logic [1:0]  dec_op, lane;
    logic        done_q, t1_q, rhv_q, first_q, wpend_q;
    logic        sample, launch, sel_rise, sel_fall, byte_end, dec_t1, dec_end;
    logic        dec_err, dec_go, step, rd_load, wr_take, consume, xfer_done;
    logic        len_set, rdf_set, wrf_set, fmt_set;
    logic [23:0] tbl_addr_q [TBL_DEPTH];
    logic [8:0]  tbl_len_q  [TBL_DEPTH];
    logic        tbl_ai_q   [TBL_DEPTH];

    // two-stage sync, single system clock domain
    always_ff @(posedge clk) begin
        if (reset) begin
            sck_q  <= 3'h0;
            sel_q  <= 3'h7;
            mosi_q <= 2'h0;
        end else begin
            sck_q  <= {sck_q[1:0], link_clk};
            sel_q  <= {sel_q[1:0], host_select_n};
            mosi_q <= {mosi_q[0], mosi};
        end
    end

    assign sample   = ctrl_q[CTRL_FALL] ? (~sck_q[1] & sck_q[2]) : (sck_q[1] & ~sck_q[2]);
    assign launch   = ctrl_q[CTRL_FALL] ? (sck_q[1] & ~sck_q[2]) : (~sck_q[1] & sck_q[2]);
    assign sel_rise = sel_q[1] & ~sel_q[2];
    assign sel_fall = ~sel_q[1] & sel_q[2];
    assign byte_end = bit_q[2:0] == BYTE_LAST;
    assign sh_n     = ctrl_q[CTRL_MSB] ? {sh_q[30:0], mosi_q[1]} : {mosi_q[1], sh_q[31:1]};
    // Bit order inside each data byte follows the same setting
    assign dbyte    = ctrl_q[CTRL_MSB] ? sh_n[7:0] : sh_n[31:24];
    assign lane     = addr_q[1:0];

    // Header decode, valid only at the header's last bit
    always_comb begin
        // table form only when MSB first
        dec_t1   = ctrl_q[CTRL_MSB] && bit_q == HDR1_LAST && sh_n[7];
        dec_end  = dec_t1 || bit_q == HDR0_LAST;
        // op code position per header form
        dec_op   = dec_t1 ? sh_n[6:5] : sh_n[30:29];
        dec_cid  = sh_n[3:0];
        lat      = {1'b0, dec_op == OP_WR ? ctrl_q[CTRL_WDUM +: 3] : ctrl_q[CTRL_RDLY +: 3]} + 4'h1;
        if (dec_t1) begin
            dec_addr = tbl_addr_q[dec_cid[2:0]];
            dec_len  = tbl_len_q[dec_cid[2:0]];
            dec_err  = dec_cid > CID_MAX || dec_op == OP_RSV
                       || (dec_op != OP_TBL && dec_len == 9'h000);
        end else begin
            dec_addr = sh_n[23:0];
            dec_len  = {4'h0, sh_n[28:24]} - {5'h00, lat};
            // table write in direct form or no data
            dec_err  = dec_op == OP_TBL || dec_op == OP_RSV || sh_n[28:24] <= {1'b0, lat};
        end
        // Table loads stay internal, never reach the core
        dec_go = state_q == ST_HDR && sample && dec_end && !dec_err && dec_op != OP_TBL;
    end

    assign step      = sample && byte_end && ((state_q == ST_WDAT)
                       || (state_q == ST_RDLY && dum_q == 3'h0)
                       || (state_q == ST_RDAT && rem_q != 9'h000));
    assign rd_load   = step && state_q != ST_WDAT;
    assign wr_take   = step && state_q == ST_WDAT;
    assign consume   = lane == 2'h3 || is_sdio(addr_q) || rem_q == 9'h001;
    assign xfer_done = (wr_take && rem_q == 9'h001)
                       || (sample && byte_end && state_q == ST_RDAT && rem_q == 9'h000);

    // Transaction sequencer
    always_ff @(posedge clk) begin
        if (reset || sel_rise) begin
            state_q <= ST_IDLE;
            bit_q   <= 5'h00;
            done_q  <= 1'b0;
        end else if (sel_fall) begin
            state_q <= ST_HDR;
            bit_q   <= 5'h00;
            done_q  <= 1'b0;
        end else if (sample && state_q != ST_IDLE) begin
            sh_q  <= sh_n;
            bit_q <= bit_q + 5'h01;
            if (step) begin
                rem_q  <= rem_q - 9'h001;
                addr_q <= adv(addr_q);
            end
            case (state_q)
                ST_HDR:
                    // decode at the header's last bit, after one byte in table form or four bytes in direct form
                    if (dec_end) begin
                        bit_q <= 5'h00;
                        t1_q  <= dec_t1;
                        cid_q <= dec_cid[2:0];
                        if (dec_err) begin
                            state_q <= ST_HOLD;
                        end else if (dec_op == OP_TBL) begin
                            state_q <= ST_TBL;
                            rem_q   <= TBL_BYTES;
                        end else begin
                            addr_q  <= dec_addr;
                            rem_q   <= dec_len;
                            dum_q   <= 3'(lat - 4'h1);
                            state_q <= dec_op == OP_WR ? ST_WDUM : ST_RDLY;
                        end
                    end
                ST_TBL:
                    if (byte_end) begin
                        tsh_q <= {dbyte, tsh_q[39:8]};
                        rem_q <= rem_q - 9'h001;
                        if (rem_q == 9'h001) begin
                            state_q <= ST_HOLD;
                            done_q  <= 1'b1;
                        end
                    end
                ST_WDUM:
                    if (byte_end) begin
                        dum_q <= dum_q - 3'h1;
                        if (dum_q == 3'h0)
                            state_q <= ST_WDAT;
                    end
                ST_RDLY:
                    if (byte_end) begin
                        dum_q <= dum_q - 3'h1;
                        if (dum_q == 3'h0)
                            state_q <= ST_RDAT;
                    end
                ST_WDAT, ST_RDAT:
                    if (xfer_done) begin
                        state_q <= ST_HOLD;
                        done_q  <= 1'b1;
                    end
                ST_HOLD:
                    state_q <= ST_HOLD;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < TBL_DEPTH; i++) begin
                tbl_addr_q[i] <= 24'h000000;
                tbl_len_q[i]  <= 9'h000;
                tbl_ai_q[i]   <= 1'b0;
            end
        end else if (state_q == ST_TBL && sample && byte_end && rem_q == 9'h001) begin
            tbl_ai_q[cid_q]   <= tsh_q[8];
            tbl_len_q[cid_q]  <= tsh_q[17:9];
            tbl_addr_q[cid_q] <= {dbyte[1:0], tsh_q[39:18]};
        end else if (xfer_done && t1_q && tbl_ai_q[cid_q]) begin
            tbl_addr_q[cid_q] <= tbl_addr_q[cid_q] + {15'h0000, tbl_len_q[cid_q]};
        end
    end

    // Core side: command, read fetch and write packing
    always_comb begin
        wmerge = wbuf_q;
        wmerge[8 * lane +: 8] = dbyte;
        wbe_m  = wbe_q | (4'h1 << lane);
        rbyte  = rhv_q ? rhold_q[8 * lane +: 8] : 8'h00;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            core_cmd_valid <= 1'b0;
            core_cmd_write <= 1'b0;
            core_cmd_addr  <= 24'h000000;
            core_cmd_len   <= 9'h000;
            core_rd_req    <= 1'b0;
            core_rd_addr   <= 24'h000000;
            core_wr_valid  <= 1'b0;
            core_wr_addr   <= 24'h000000;
            core_wr_data   <= 32'h00000000;
            core_wr_be     <= 4'h0;
            wake_req       <= 1'b0;
            wbuf_q         <= 32'h00000000;
            wbe_q          <= 4'h0;
            rhv_q          <= 1'b0;
            rhold_q        <= 32'h00000000;
            first_q        <= 1'b0;
            osh_q          <= 8'h00;
        end else begin
            core_cmd_valid <= dec_go;
            core_rd_req    <= 1'b0;
            core_wr_valid  <= 1'b0;
            wake_req       <= dec_go && (dec_op == OP_WR || ctrl_q[CTRL_WAKE]);
            if (dec_go) begin
                core_cmd_write <= dec_op == OP_WR;
                core_cmd_addr  <= dec_addr;
                core_cmd_len   <= dec_len;
                core_rd_req    <= dec_op == OP_RD;
                core_rd_addr   <= dec_addr;
                first_q        <= dec_op == OP_RD;
                wbe_q          <= 4'h0;
            end
            if (rd_load) begin
                first_q <= 1'b0;
                osh_q   <= rbyte;
                if (consume && rem_q != 9'h001) begin
                    core_rd_req  <= 1'b1;
                    core_rd_addr <= adv(addr_q);
                end
            end else if (launch && state_q == ST_RDAT) begin
                osh_q <= ctrl_q[CTRL_MSB] ? {osh_q[6:0], 1'b0} : {1'b0, osh_q[7:1]};
            end
            // New data wins over consumption
            if (core_rd_valid) begin
                rhv_q   <= 1'b1;
                rhold_q <= core_rd_data;
            end else if (rd_load && consume) begin
                rhv_q <= 1'b0;
            end
            // pack bytes into dwords with enables
            if (wr_take) begin
                wbuf_q <= wmerge;
                wbe_q  <= consume ? 4'h0 : wbe_m;
                if (consume) begin
                    core_wr_valid <= 1'b1;
                    core_wr_addr  <= is_sdio(addr_q) ? addr_q : {addr_q[23:2], 2'b00};
                    core_wr_data  <= wmerge;
                    core_wr_be    <= wbe_m;
                end
            end
        end
    end

    // shift read bytes out while host clocks the read data phase, miso held low during dummies
    always_ff @(posedge clk) begin
        // Cut read must not leave a stale bit on the line
        if (reset || sel_rise)
            miso <= 1'b0;
        else if (launch)
            miso <= state_q == ST_RDAT && (ctrl_q[CTRL_MSB] ? osh_q[7] : osh_q[0]);
    end

    assign rdf_set = rd_load && first_q && !rhv_q && !core_rd_valid;
    assign wrf_set = wr_take && consume && wpend_q && !core_wr_ack;
    // ends at select release, sticky interrupt
    assign fmt_set = state_q == ST_HDR && sample && dec_end && dec_err;
    // extra edges after completion or early release
    assign len_set = (sample && state_q == ST_HOLD && done_q)
                     || (sel_rise && state_q != ST_IDLE && state_q != ST_HOLD);

    always_ff @(posedge clk) begin
        if (reset)
            wpend_q <= 1'b0;
        else if (wr_take && consume)
            wpend_q <= 1'b1;
        else if (core_wr_ack)
            wpend_q <= 1'b0;
    end

    // AXI4-Lite slave; one write and one read in flight
    logic [7:0]  awa_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        wr_fire, clr_hit;

    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign clr_hit = wr_fire && awa_q == SSP_STAT_OFS && ws_q[0];

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OK;
            ctrl_q        <= CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awa_q         <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q         <= s_axi_wdata;
                ws_q         <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awa_q == SSP_CTRL_OFS || awa_q == SSP_STAT_OFS)
                                ? RESP_OK : RESP_SLVERR;
                if (awa_q == SSP_CTRL_OFS) begin
                    if (ws_q[0])
                        ctrl_q[7:0] <= wd_q[7:0];
                    if (ws_q[1])
                        ctrl_q[8] <= wd_q[8];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // sticky flags, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_q <= 4'h0;
            irq    <= 1'b0;
        end else begin
            flag_q <= (flag_q & ~(clr_hit ? wd_q[3:0] : 4'h0))
                      | {len_set, wrf_set, rdf_set, fmt_set};
            irq    <= |flag_q[ST_WRF:ST_FMT];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OK;
            s_axi_rdata   <= 32'h00000000;
            if (s_axi_araddr == SSP_CTRL_OFS)
                s_axi_rdata[8:0] <= ctrl_q;
            else if (s_axi_araddr == SSP_STAT_OFS)
                s_axi_rdata[ST_BUSY:0] <= {state_q != ST_IDLE, flag_q};
            else
                s_axi_rresp <= RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: verification/ssp_host_model.sv
// Behavioural serial host that frames link transfers
`timescale 1ns/100ps
`default_nettype none
module ssp_host_model (
    output logic       link_clk,
    output logic       host_select_n,
    output logic       mosi,
    input  wire logic  miso
);
    logic [255:0] rx_q;
    initial
    begin
        link_clk = 1'b0;
        host_select_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input logic [255:0] tx, input int n);
        #1.3;
        host_select_n = 1'b0;
        for (int k = 0; k <= n; k++)
        begin
            link_clk = 1'b0;
            // Sampled just before the next launch
            if (k > 0) rx_q[n - k] = miso;
            mosi = (k < n) ? tx[n - 1 - k] : ~mosi;
            #16;
            if (k < n) link_clk = 1'b1;
            #16;
        end
        host_select_n = 1'b1;
        #40;
    endtask
endmodule
`default_nettype wire

// file: verification/ssp_port_sva.sv
// Port assertions for the serial slave host port
`timescale 1ns/100ps
`default_nettype none
module ssp_port_sva
    import ssp_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        host_select_n,
    input wire logic        miso,
    input wire logic        core_cmd_valid,
    input wire logic        wake_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_unmapped;
        s_ar_take ##0 (s_axi_araddr != SSP_CTRL_OFS && s_axi_araddr != SSP_STAT_OFS);
    endsequence
    property p_b_late; s_axi_awvalid && s_axi_awready |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
    a_b_late: assert property (p_b_late) else $error("write answer mistimed");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_first; s_ar_take |=> s_axi_rvalid; endproperty
    a_r_first: assert property (p_r_first) else $error("read answer late");
    property p_unmapped; s_unmapped |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer changed");
    property p_cmd_pulse; core_cmd_valid |=> !core_cmd_valid; endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse long");
    property p_wake; wake_req |-> core_cmd_valid; endproperty
    a_wake: assert property (p_wake) else $error("wake without command");
    property p_miso_idle; host_select_n [*8] |-> !miso; endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("miso driven idle");
endmodule
bind ssp_serial_slave_host_port ssp_port_sva u_sva (.*);
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the serial slave host port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ssp_pkg::*;
    logic         clk, reset = 1'b1, no_rd = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic         core_rd_valid = 1'b0, core_wr_ack = 1'b0;
    logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]  s_axi_wdata = 32'h0, core_rd_data = 32'h0, s_axi_rdata, core_wr_data;
    logic [31:0]  rdv, w, sw, d;
    logic [3:0]   s_axi_wstrb = 4'hF, core_wr_be;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic         link_clk, host_select_n, mosi, miso, core_cmd_valid, core_cmd_write;
    logic         core_rd_req, core_wr_valid, wake_req, irq;
    logic [23:0]  core_cmd_addr, core_rd_addr, core_wr_addr, a;
    logic [8:0]   core_cmd_len;
    logic [2:0]   wd, rl;
    logic [33:0]  cmd_q;
    logic [59:0]  wr_q;
    logic [255:0] tx;
    int           seed = 36948, fail_count = 0, total_checks = 0, wake_n = 0, wk;
    ssp_serial_slave_host_port uut (.*);
    ssp_host_model host (.*);
    initial
    begin
        clk = 1'b0;
        // clock rate fixed for the whole run
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] exp_word(input logic [23:0] ad);
        return 32'h5A3C0000 ^ {8'h00, ad[23:2], 2'b00};
    endfunction
    // Core side answers promptly unless starved on purpose
    always @(posedge clk)
    begin
        core_rd_valid <= core_rd_req && !no_rd;
        core_rd_data <= exp_word(core_rd_addr);
        core_wr_ack <= core_wr_valid && !no_rd;
        if (core_cmd_valid) cmd_q <= {core_cmd_write, core_cmd_len, core_cmd_addr};
        if (core_wr_valid) wr_q <= {core_wr_be, core_wr_addr, core_wr_data};
        wake_n <= wake_n + int'(wake_req);
    end
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] ev, input logic [63:0] sv);
        total_checks++;
        if (sv !== ev)
        begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", nm, ev, sv);
        end
    endtask
    task automatic guard(input int t);
        if (t >= 40)
        begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dv);
        int t;
        @(posedge clk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (t = 0; t < 40; t++)
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        guard(t);
    endtask
    task automatic rd(input logic [7:0] ad);
        int t;
        @(posedge clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (t = 0; t < 40; t++)
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        guard(t);
    endtask
    // Sticky flags read, irq seen, then cleared
    // status polled after the rejected direct-form table op, the short transfer, each read and the lsb write
    task automatic stat(input logic [31:0] ev, input logic ie);
        rd(SSP_STAT_OFS);
        chk("status", ev, rdv & 32'hF);
        chk("irq", ie, irq);
        wr(SSP_STAT_OFS, 32'hF);
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(SSP_CTRL_OFS);
        chk("ctrl reset", CTRL_RST, rdv);
        rd(8'h0C);
        chk("unmapped resp", RESP_SLVERR, rsp);
        wd = 3'($random(seed));
        rl = 3'($random(seed));
        wr(SSP_CTRL_OFS, {23'h0, 1'b0, rl, wd, 2'b01});
        rd(SSP_CTRL_OFS);
        chk("ctrl", {23'h0, 1'b0, rl, wd, 2'b01}, rdv);
        a = 24'($random(seed)) & 24'h7FFFFC;
        host.xfer({1'b0, OP_TBL, 5'h05, a, 8'h00}, 40);
        stat(32'h1, 1'b1);
        host.xfer(12'($random(seed)) & 12'h7FF, 12);
        stat(32'h8, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            a = 24'($random(seed)) & 24'h7FFFFC;
            d = $random(seed);
            sw = {<<8{d}};
            wk = wake_n;
            tx = {1'b0, OP_WR, 5'(wd) + 5'h05, a};
            host.xfer((tx << (8 * wd + 40)) | sw, 8 * wd + 72);
            chk("write cmd", {1'b1, 9'h004, a}, cmd_q);
            chk("write dword", {4'hF, a, d}, wr_q);
            chk("write wake", wk + 1, wake_n);
        end
        for (int m = 0; m < 2; m++)
        begin
            no_rd <= m[0];
            wr(SSP_CTRL_OFS, {23'h0, m[0], rl, wd, 2'b01});
            a = 24'($random(seed)) & 24'h7FFFFC;
            wk = wake_n;
            tx = {1'b0, OP_RD, 5'(rl) + 5'h05, a};
            host.xfer((tx << (8 * rl + 40)) | 32'($random(seed)), 8 * rl + 72);
            w = exp_word(a);
            sw = m ? 32'h0 : {<<8{w}};
            chk("read bytes", sw, host.rx_q[31:0]);
            chk("read cmd", {1'b0, 9'h004, a}, cmd_q);
            chk("read wake", wk + m, wake_n);
            stat(m ? 32'h2 : 32'h0, m[0]);
        end
        // Table row with auto-increment, one byte too many
        a = 24'($random(seed)) & 24'h7FFFFC;
        tx = 256'h0;
        tx[47:8] = {<<8{6'h00, a, 9'h004, 1'b1}};
        tx[55:48] = {1'b1, OP_TBL, 2'b00, 3'h5};
        host.xfer(tx, 56);
        // Acks withheld: second dword finds the first unanswered
        for (int j = 0; j < 2; j++)
        begin
            d = $random(seed);
            sw = {<<8{d}};
            tx = {1'b1, OP_WR, 5'h05};
            host.xfer((tx << (8 * wd + 40)) | sw, 8 * wd + 48);
            chk("table cmd", {1'b1, 9'h004, a + 24'(4 * j)}, cmd_q);
            chk("table dword", {4'hF, a + 24'(4 * j), d}, wr_q);
        end
        // Least significant bit first, header reversed as a whole
        wr(SSP_CTRL_OFS, {23'h0, 1'b0, rl, wd, 2'b00});
        a = 24'($random(seed)) & 24'h7FFFFC;
        d = $random(seed);
        sw = {<<{d}};
        w = {1'b0, OP_WR, 5'(wd) + 5'h05, a};
        tx = 256'h0;
        tx[31:0] = {<<{w}};
        host.xfer((tx << (8 * wd + 40)) | sw, 8 * wd + 72);
        chk("lsb cmd", {1'b1, 9'h004, a}, cmd_q);
        chk("lsb dword", {4'hF, a, d}, wr_q);
        stat(32'hC, 1'b1);
        close_out();
    end
endmodule
`default_nettype wire
